/* rtl/bsi_busy_status.sv */
`timescale 1ns/100ps
// What this block does
// - detect peaks only inside common or connector window
// - veto suppresses conversion of detected peaks
// - busy on convert, reset, test, full
// - own busy in status bit 2
// - busy drives wired OR and NAND lines
// - sensed OR busy line in bit 3
// - window is common OR connector window
// - ack lamp pulses on each bus access
// - busy lamp follows busy, plus configuration
// - ready lamp on nonempty buffer, plus configuration
// - termination lamp green, red, off, orange
// - power lamp green, orange on overcurrent
// - jumper picks global or local halt
// - busy rises at window opening, falls after conversion or vetoed window
// - window pulses ignored while busy
module bsi_busy_status import bsi_pkg::*; #(
    parameter int CFG_CYC = CFG_DEFAULT_CYC
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic gate_common,
    input wire logic gate_conn,
    input wire logic veto,
    input wire logic busy_wor_i,
    input wire logic analog_resetting,
    input wire logic buffer_full,
    input wire logic buffer_nonempty,
    input wire logic busy_scope_jumper,
    input wire logic [6:0] term_on,
    input wire logic overcurrent,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic peak_detect_en,
    output logic convert_start,
    output logic acq_halt,
    output bsi_busline_t busline,
    output bsi_lamps_t lamps
);

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    localparam int NSYNC = 16;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    assign raw_in = {overcurrent, term_on, busy_scope_jumper, buffer_nonempty,
        buffer_full, analog_resetting, busy_wor_i, veto, gate_conn,
        gate_common};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= raw_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate

    logic s_gate_com, s_gate_con, s_veto, s_wor, s_ares, s_full, s_nemp;
    logic s_jump, s_ovc;
    logic [6:0] s_term;
    assign {s_ovc, s_term, s_jump, s_nemp, s_full, s_ares, s_wor, s_veto,
        s_gate_con, s_gate_com} = sync2_r;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WINDOW,
        ST_CONVERT
    } bsi_state_t;

    bsi_state_t state_r, state_nxt;
    logic gate_r, gate_nxt;
    logic veto_seen_r, veto_seen_nxt;
    logic [CNT_W-1:0] conv_cnt_r, conv_cnt_nxt;
    logic [CNT_W-1:0] ack_cnt_r, ack_cnt_nxt;
    logic [CNT_W-1:0] cfg_cnt_r, cfg_cnt_nxt;
    logic [1:0] ctrl_r, ctrl_nxt;
    logic [31:0] rdata_nxt;
    logic busy_nxt, busy_r;
    logic halt_nxt, start_nxt, pden_nxt;
    bsi_busline_t bl_nxt;
    bsi_lamps_t lamps_nxt;
    logic gate_eff, conv_active, cfg_active;

    always_comb begin
        gate_eff = s_gate_com | s_gate_con;
        state_nxt = state_r;
        gate_nxt = gate_eff;
        veto_seen_nxt = veto_seen_r;
        conv_cnt_nxt = conv_cnt_r;
        start_nxt = 1'b0;
        case (state_r)
            ST_IDLE: begin
                // new window only when not halted
                if (gate_eff && !gate_r && !acq_halt) begin
                    state_nxt = ST_WINDOW;
                    veto_seen_nxt = s_veto;
                end
            end
            ST_WINDOW: begin
                if (s_veto) begin
                    veto_seen_nxt = 1'b1;
                end
                if (!gate_eff) begin
                    if (veto_seen_r || s_veto) begin
                        state_nxt = ST_IDLE;
                    end else begin
                        state_nxt = ST_CONVERT;
                        start_nxt = 1'b1;
                        conv_cnt_nxt = CNT_W'(CONV_CYC);
                    end
                end
            end
            ST_CONVERT: begin
                if (conv_cnt_r <= CNT_W'(1)) begin
                    state_nxt = ST_IDLE;
                    conv_cnt_nxt = '0;
                end else begin
                    conv_cnt_nxt = conv_cnt_r - CNT_W'(1);
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        // peaks only inside the accepted window
        pden_nxt = (state_nxt == ST_WINDOW);
        conv_active = (state_nxt != ST_IDLE);
        busy_nxt = conv_active | s_ares | s_full | ctrl_r[CTRL_MTEST_BIT]
            | ctrl_nxt[CTRL_MTEST_BIT];
        halt_nxt = s_jump ? (busy_nxt | s_wor) : busy_nxt;
        bl_nxt.wor_o = 1'b1;
        bl_nxt.wor_oe = busy_nxt;
        bl_nxt.wnand_o = 1'b0;
        bl_nxt.wnand_oe = busy_nxt;
    end

    // ---------------------------------------------------------------
    // register port and lamps
    // ---------------------------------------------------------------
    always_comb begin
        ctrl_nxt = ctrl_r;
        rdata_nxt = 32'h0;
        ack_cnt_nxt = (ack_cnt_r != '0) ? ack_cnt_r - CNT_W'(1) : '0;
        cfg_cnt_nxt = (cfg_cnt_r != '0) ? cfg_cnt_r - CNT_W'(1) : '0;
        cfg_active = (cfg_cnt_r != '0);
        if (reg_wr || reg_rd) begin
            ack_cnt_nxt = CNT_W'(ACK_LAMP_CYC);
        end
        if (reg_wr && reg_addr == CTRL_ADDR) begin
            ctrl_nxt = reg_wdata[1:0];
        end
        if (reg_rd) begin
            case (reg_addr)
                STAT_ADDR: begin
                    rdata_nxt[STAT_DATA_READY_INDICATOR_BIT] = s_nemp;
                    rdata_nxt[STAT_BUSY_BIT] = busy_r;
                    rdata_nxt[STAT_GBUSY_BIT] = s_wor;
                end
                CTRL_ADDR: rdata_nxt[1:0] = ctrl_r;
                DIAG_ADDR: rdata_nxt[1:0] = state_r;
                default: rdata_nxt = 32'h0;
            endcase
        end
        lamps_nxt.ack = (ack_cnt_nxt != '0);
        lamps_nxt.busy = busy_nxt | cfg_active;
        lamps_nxt.data_ready = s_nemp | cfg_active;
        if (cfg_active) begin
            lamps_nxt.term = TERM_ORANGE;
        end else if (&s_term) begin
            lamps_nxt.term = TERM_GREEN;
        end else if (s_term == 7'h00) begin
            lamps_nxt.term = TERM_RED;
        end else begin
            lamps_nxt.term = TERM_OFF;
        end
        lamps_nxt.power_green = !s_ovc;
        lamps_nxt.power_orange = s_ovc;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            gate_r <= 1'b0;
            veto_seen_r <= 1'b0;
            conv_cnt_r <= '0;
            ack_cnt_r <= '0;
            cfg_cnt_r <= CNT_W'(CFG_CYC);
            ctrl_r <= CTRL_RESET_VAL;
            reg_rdata <= 32'h0;
            busy_r <= 1'b0;
            acq_halt <= 1'b0;
            convert_start <= 1'b0;
            peak_detect_en <= 1'b0;
            busline <= '0;
            lamps <= '0;
        end else begin
            state_r <= state_nxt;
            gate_r <= gate_nxt;
            veto_seen_r <= veto_seen_nxt;
            conv_cnt_r <= conv_cnt_nxt;
            ack_cnt_r <= ack_cnt_nxt;
            cfg_cnt_r <= cfg_cnt_nxt;
            ctrl_r <= ctrl_nxt;
            reg_rdata <= rdata_nxt;
            busy_r <= busy_nxt;
            acq_halt <= halt_nxt;
            convert_start <= start_nxt;
            peak_detect_en <= pden_nxt;
            busline <= bl_nxt;
            lamps <= lamps_nxt;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence conv_begin;
        convert_start ##1 busy_r;
    endsequence

    a_busy_out_mirror: assert property (
        busline.wor_oe == busy_r && busline.wnand_oe == busy_r)
        else $error("busy lines do not follow busy");
    a_conv_busy: assert property (convert_start |-> busy_r)
        else $error("busy low during conversion start");
    a_conv_len: assert property (
        conv_begin |-> busy_r [*8])
        else $error("busy dropped early in conversion");
    a_full_busy: assert property ($past(s_full) |-> busy_r)
        else $error("buffer full without busy");
    a_local_halt: assert property (
        !$past(s_jump) |-> acq_halt == busy_r)
        else $error("local halt mismatch");
    a_global_halt: assert property (
        $past(s_jump) && $past(s_wor) |-> acq_halt)
        else $error("global halt missing");
    a_busy_lamp: assert property (busy_r |-> lamps.busy)
        else $error("busy lamp dark while busy");
    a_ack_lamp: assert property ((reg_wr || reg_rd) |=> lamps.ack)
        else $error("ack lamp missed access");
    a_stat_bits: assert property (
        reg_rd && reg_addr == STAT_ADDR |=> reg_rdata[STAT_BUSY_BIT]
        == $past(busy_r))
        else $error("status busy bit wrong");
    a_power_lamp: assert property (
        $past(reset_n) |-> lamps.power_orange != lamps.power_green)
        else $error("power lamp both or neither");

    sequence ack_lit;
        $rose(lamps.ack);
    endsequence

    sequence conv_last;
        state_r == ST_CONVERT && conv_cnt_r == CNT_W'(1);
    endsequence

    a_pden_in_window: assert property (
        peak_detect_en |-> $past(s_gate_com | s_gate_con))
        else $error("peak detect outside window");
    a_veto_blocks: assert property (
        convert_start |-> !$past(veto_seen_r) && !$past(s_veto))
        else $error("conversion started despite veto");
    a_mtest_busy: assert property (
        $past(ctrl_r[CTRL_MTEST_BIT]) |-> busy_r)
        else $error("memory test without busy");
    a_ares_busy: assert property ($past(s_ares) |-> busy_r)
        else $error("analog reset without busy");
    a_gbusy_bit: assert property (
        reg_rd && reg_addr == STAT_ADDR |=> reg_rdata[STAT_GBUSY_BIT]
        == $past(s_wor))
        else $error("status bus busy bit wrong");
    a_ack_hold: assert property (ack_lit |=> lamps.ack [*8])
        else $error("ack lamp too short");
    a_cfg_lamps: assert property (
        $past(reset_n) && $past(cfg_active) |-> lamps.busy
        && lamps.data_ready && lamps.term == TERM_ORANGE)
        else $error("configuration lamps wrong");
    a_data_lamp: assert property (
        $past(s_nemp) |-> lamps.data_ready)
        else $error("ready lamp dark with data");
    a_term_green: assert property (
        $past(&s_term) && !$past(cfg_active) |-> lamps.term == TERM_GREEN)
        else $error("termination lamp not green");
    a_term_red: assert property (
        $past(s_term == 7'h00) && !$past(cfg_active)
        |-> lamps.term == TERM_RED)
        else $error("termination lamp not red");
    a_halt_blocks: assert property (
        acq_halt && state_r == ST_IDLE |=> !peak_detect_en)
        else $error("window accepted while halted");
    a_conv_done: assert property (
        conv_last |=> state_r == ST_IDLE && !convert_start)
        else $error("conversion did not end");

endmodule // bsi_busy_status

/* rtl/bsi_pkg.sv */
package bsi_pkg;

    // ---------------------------------------------------------------
    // register map and status word layout
    // ---------------------------------------------------------------
    localparam logic [7:0] STAT_ADDR = 8'h00;
    localparam logic [7:0] CTRL_ADDR = 8'h04;
    localparam logic [7:0] DIAG_ADDR = 8'h08;
    localparam int STAT_DATA_READY_INDICATOR_BIT = 0;
    localparam int STAT_BUSY_BIT = 2;
    localparam int STAT_GBUSY_BIT = 3;
    localparam int CTRL_MTEST_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam logic [1:0] CTRL_RESET_VAL = 2'h0;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int ACK_LAMP_NS = 1000;
    localparam int ACK_LAMP_CYC = ACK_LAMP_NS / CLK_PERIOD_NS;
    localparam int CONV_NS = 5700;
    localparam int CONV_CYC = (CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CFG_DEFAULT_CYC = 20000;
    localparam int CNT_W = 16;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        TERM_OFF,
        TERM_GREEN,
        TERM_RED,
        TERM_ORANGE
    } bsi_term_t;

    typedef struct packed {
        logic ack;
        logic busy;
        logic data_ready;
        bsi_term_t term;
        logic power_green;
        logic power_orange;
    } bsi_lamps_t;

    typedef struct packed {
        logic wor_o;
        logic wor_oe;
        logic wnand_o;
        logic wnand_oe;
    } bsi_busline_t;

endpackage

/* sim/bsi_chain_model.sv */
`timescale 1ns/100ps
// ---------------------------------------------------------------
// other boards sharing the busy lines
// ---------------------------------------------------------------
module bsi_chain_model import bsi_pkg::*; (
    input wire bsi_busline_t busline,
    input wire logic other_busy,
    output logic wor_level,
    output logic wnand_level
);
    // wired OR line and its wired NAND partner
    assign wor_level = (busline.wor_oe & busline.wor_o) | other_busy;
    assign wnand_level = ~((busline.wnand_oe & ~busline.wnand_o)
        | other_busy);
endmodule // bsi_chain_model

/* sim/busy_status_indication_bench.sv */
`timescale 1ns/100ps
module busy_status_indication_bench import bsi_pkg::*;;
    logic core_clk = 0;
    logic reset_n = 0;
    logic gate_common, gate_conn, veto, analog_resetting, buffer_full;
    logic buffer_nonempty, busy_scope_jumper, overcurrent, reg_wr, reg_rd;
    logic other_busy, peak_detect_en, convert_start, acq_halt, pk_q;
    logic wor_level, wnand_level;
    logic [6:0] term_on;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    bsi_busline_t busline;
    bsi_lamps_t lamps;
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;
    int pk_n = 0;
    int cs_n = 0;
    int cs_at = 0;
    int exp_pk = 0;
    int exp_cs = 0;
    int n;

    bsi_busy_status #(.CFG_CYC(20)) dut (.core_clk(core_clk),
        .reset_n(reset_n), .gate_common(gate_common), .gate_conn(gate_conn),
        .veto(veto), .busy_wor_i(wor_level),
        .analog_resetting(analog_resetting), .buffer_full(buffer_full),
        .buffer_nonempty(buffer_nonempty),
        .busy_scope_jumper(busy_scope_jumper), .term_on(term_on),
        .overcurrent(overcurrent), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .peak_detect_en(peak_detect_en),
        .convert_start(convert_start), .acq_halt(acq_halt),
        .busline(busline), .lamps(lamps));
    bsi_chain_model chain (.busline(busline), .other_busy(other_busy),
        .wor_level(wor_level), .wnand_level(wnand_level));

    always #2.5 core_clk = ~core_clk;

    // ---------------------------------------------------------------
    // event counters and timeout
    // ---------------------------------------------------------------
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        pk_q <= peak_detect_en;
        if (peak_detect_en && !pk_q) pk_n <= pk_n + 1;
        if (convert_start) begin
            cs_n <= cs_n + 1;
            cs_at <= cyc;
        end
        if (cyc == 20000) begin
            failures = failures + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic c1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    function automatic logic [31:0] st(input logic o, s, r);
        return {28'h0, s, o, 1'b0, r};
    endfunction

    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic win(input logic cn, input logic vt);
        @(posedge core_clk);
        gate_conn <= cn;
        gate_common <= !cn;
        repeat (5) @(posedge core_clk);
        veto <= vt;
        repeat (10 + $urandom_range(0, 20)) @(posedge core_clk);
        gate_conn <= 1'b0;
        gate_common <= 1'b0;
        veto <= 1'b0;
        tick(8);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        n = $urandom(32'h9000186B);
        {gate_common, gate_conn, veto, analog_resetting} = 4'h0;
        {buffer_full, buffer_nonempty, busy_scope_jumper} = 3'h0;
        {overcurrent, reg_wr, reg_rd, other_busy} = 4'h0;
        term_on = 7'h7F;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        tick(5);
        c1(lamps.busy, 1'b1);
        c1(lamps.data_ready, 1'b1);
        chk(32'(lamps.term), 32'(TERM_ORANGE));
        tick(30);
        c1(lamps.busy, 1'b0);
        c1(lamps.power_green, 1'b1);
        for (int i = 0; i < 3; i++) begin
            term_on <= (i == 0) ? 7'h7F : (i == 1) ? 7'h00
                : 7'($urandom_range(1, 126));
            tick(5);
            chk(32'(lamps.term), (i == 0) ? 32'(TERM_GREEN)
                : (i == 1) ? 32'(TERM_RED) : 32'(TERM_OFF));
        end
        overcurrent <= 1'b1;
        tick(5);
        c1(lamps.power_orange, 1'b1);
        overcurrent <= 1'b0;
        buffer_nonempty <= 1'b1;
        tick(5);
        c1(lamps.data_ready, 1'b1);
        rd(STAT_ADDR);
        chk(d & 32'h0000000D, st(1'b0, 1'b0, 1'b1));
        c1(lamps.ack, 1'b1);
        tick(ACK_LAMP_CYC + 10);
        c1(lamps.ack, 1'b0);
        buffer_nonempty <= 1'b0;
        wr(8'hFC, $urandom);
        rd(8'hFC);
        chk(d, 32'h0);
        for (int i = 0; i < 3; i++) begin
            analog_resetting <= (i == 0);
            buffer_full <= (i == 1);
            if (i == 2) wr(CTRL_ADDR, 32'h1);
            tick(5);
            c1(lamps.busy, 1'b1);
            c1(acq_halt, 1'b1);
            chk(32'(busline), 32'hD);
            c1(wnand_level, 1'b0);
            rd(STAT_ADDR);
            chk(d & 32'h0000000D, st(1'b1, 1'b1, 1'b0));
        end
        analog_resetting <= 1'b0;
        buffer_full <= 1'b0;
        wr(CTRL_ADDR, 32'h0);
        tick(5);
        chk(32'({busline.wor_oe, busline.wnand_oe}), 32'h0);
        c1(lamps.data_ready, 1'b0);
        other_busy <= 1'b1;
        for (int j = 0; j < 2; j++) begin
            busy_scope_jumper <= j[0];
            tick(5);
            c1(acq_halt, j[0]);
            rd(STAT_ADDR);
            chk(d & 32'h0000000D, st(1'b0, 1'b1, 1'b0));
        end
        other_busy <= 1'b0;
        busy_scope_jumper <= 1'b0;
        tick(5);
        for (int j = 0; j < 2; j++) begin
            win(j[0], 1'b0);
            exp_pk++;
            exp_cs++;
            win(!j[0], 1'b0);
            chk(pk_n, exp_pk);
            chk(cs_n, exp_cs);
            n = 0;
            while (acq_halt && n < 1300) begin
                tick(1);
                n++;
            end
            c1((cyc - cs_at) >= CONV_CYC && (cyc - cs_at) <= CONV_CYC + 5,
                1'b1);
        end
        win(1'b0, 1'b1);
        exp_pk++;
        chk(pk_n, exp_pk);
        chk(cs_n, exp_cs);
        c1(acq_halt, 1'b0);
        print_verdict();
    end
endmodule // busy_status_indication_bench
